// file: logic/motor_chain_map.svh
`ifndef MOTOR_CHAIN_MAP_SVH
`define MOTOR_CHAIN_MAP_SVH

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MVC_RES_HI_MSB    31
`define MVC_RES_HI_LSB    16
`define MVC_TRIG_SEL_ADC  2'h2

// ----------------------------------------------------------------
// fixed-point constants: shifts, q15 ratios, angles in 16-bit turns
// ----------------------------------------------------------------
`define MVC_Q15_SHIFT     15
`define MVC_GAIN_SHIFT    8
`define MVC_INV_SQRT3     18'sh049E7
`define MVC_SQRT3_HALF    18'sh06EDA
`define MVC_QUARTER_TURN  16'h4000
`define MVC_HALF_TURN     17'h08000

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define MVC_ZERO16        16'h0000
`define MVC_CMP_WIDTH     48
`define MVC_FIFO_DEPTH    8

`endif

// file: logic/motor_chain_pkg.sv
`default_nettype none

package motor_chain_pkg;

  typedef enum logic [2:0] {
    IN_IDLE   = 3'h1,
    IN_CLARKE = 3'h2,
    IN_PARK   = 3'h4
  } in_state_t;

  typedef enum logic [3:0] {
    PWM_IDLE  = 4'h1,
    PWM_PARK  = 4'h2,
    PWM_PHASE = 4'h4,
    PWM_PUSH  = 4'h8
  } pwm_state_t;

  typedef logic signed [15:0] q15_t;

endpackage : motor_chain_pkg

`default_nettype wire

// file: logic/stream_if.sv
`default_nettype none

interface stream_if #(parameter int W = 48);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

`default_nettype wire

// file: logic/sample_fifo.sv
`default_nettype none

module sample_fifo #(
  parameter int W     = 48,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  stream_if.snk    wr,
  stream_if.src    rd
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;

  // extra pointer bit tells full from empty with no counter
  wire full  = (wp_r[AW] != rp_r[AW]) &&
               (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push  = wr.valid && !full;
  wire pop   = rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop)  rp_r <= rp_r + 1'b1;
    end
  end

endmodule : sample_fifo

`default_nettype wire

// file: logic/motor_vector_chain.sv
`include "motor_chain_map.svh"
`default_nettype none

// Operation
// - angle stage runs on upper angle change
// - electric angle is resolver plus offset
// - third phase derived, then dq transform
// - trigger select 10 starts input on ADC done
// - held angle copied at ADC trigger
// - PI chain bit starts PI on input done
// - PI makes d and q voltage results
// - PWM chain bit starts PWM on PI done
// - dq voltages to UVW, duty, compare
// - compare values delivered to PWM timer
// - phase W sample ignored, U and V used
module motor_vector_chain (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [31:0]            resolver_angle_word,
  input  wire logic [15:0]            angle_offset,
  input  wire logic                   adc_trig,
  input  wire logic                   adc_done,
  input  wire logic signed [15:0]     adc_input_phase_v,
  input  wire logic signed [15:0]     adc_input_phase_w,
  input  wire logic signed [15:0]     adc_input_phase_u,
  input  wire logic [1:0]             input_stage_trigger_sel,
  input  wire logic                   pi_stage_chain_enable,
  input  wire logic                   pwm_stage_chain_enable,
  input  wire logic                   sw_start_input,
  input  wire logic                   sw_start_pi,
  input  wire logic                   sw_start_pwm,
  input  wire logic signed [15:0]     d_current_command,
  input  wire logic signed [15:0]     q_current_command,
  input  wire logic signed [15:0]     kp_gain,
  input  wire logic signed [15:0]     ki_gain,
  input  wire logic [15:0]            pwm_period,
  output logic [15:0]                 held_electric_angle,
  output logic [15:0]                 sampled_electric_angle,
  output logic signed [15:0]          d_current_feedback,
  output logic signed [15:0]          q_current_feedback,
  output logic signed [15:0]          d_voltage_result,
  output logic signed [15:0]          q_voltage_result,
  output logic                        angle_done,
  output logic                        input_done,
  output logic                        pi_done,
  output logic                        pwm_done,
  output logic                        cmp_valid,
  input  wire logic                   cmp_ready,
  output logic [15:0]                 cmp_u,
  output logic [15:0]                 cmp_v,
  output logic [15:0]                 cmp_w
);

  // --------------------------------------------------------------
  // fixed-point helpers
  // --------------------------------------------------------------
  function automatic motor_chain_pkg::q15_t sat16(
    input logic signed [35:0] x);
    if (x > 36'sd32767)       sat16 = 16'sh7FFF;
    else if (x < -36'sd32768) sat16 = 16'sh8000;
    else                      sat16 = x[15:0];
  endfunction : sat16

  // parabolic sine, angle full scale = one turn; cheap, ~6% error
  function automatic motor_chain_pkg::q15_t sin_q15(
    input logic [15:0] a);
    logic [15:0]        mag;
    logic signed [33:0] p;
    mag = a[15] ? 16'(-a) : a;
    p   = 34'($signed(a)) *
          34'($signed({1'b0, `MVC_HALF_TURN - {1'b0, mag}}));
    sin_q15 = sat16(36'(p >>> 13));
  endfunction : sin_q15

  function automatic motor_chain_pkg::q15_t mul_q15(
    input logic signed [17:0] a,
    input logic signed [17:0] b);
    logic signed [35:0] p;
    p = 36'(a) * 36'(b);
    mul_q15 = sat16(p >>> `MVC_Q15_SHIFT);
  endfunction : mul_q15

  // --------------------------------------------------------------
  // angle stage
  // --------------------------------------------------------------
  logic [15:0] ang_prev_r;
  wire  [15:0] res_hi =
    resolver_angle_word[`MVC_RES_HI_MSB:`MVC_RES_HI_LSB];
  wire         ang_go = (res_hi != ang_prev_r);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ang_prev_r          <= `MVC_ZERO16;
      held_electric_angle <= `MVC_ZERO16;
      angle_done          <= 1'b0;
    end else begin
      ang_prev_r <= res_hi;
      angle_done <= ang_go;
      if (ang_go) held_electric_angle <= res_hi + angle_offset;
    end
  end

  // one-cycle stage, so a change can never hit a busy angle stage
  always_ff @(posedge clk) begin
    if (sys_rst) sampled_electric_angle <= `MVC_ZERO16;
    else if (adc_trig)
      sampled_electric_angle <= held_electric_angle;
  end

  wire motor_chain_pkg::q15_t sin_th = sin_q15(sampled_electric_angle);
  wire motor_chain_pkg::q15_t cos_th =
    sin_q15(sampled_electric_angle + `MVC_QUARTER_TURN);

  // --------------------------------------------------------------
  // input stage
  // --------------------------------------------------------------
  motor_chain_pkg::in_state_t in_state_r;
  motor_chain_pkg::q15_t      iu_r;
  motor_chain_pkg::q15_t      iv_r;
  motor_chain_pkg::q15_t      alpha_r;
  motor_chain_pkg::q15_t      beta_r;

  wire in_auto = (input_stage_trigger_sel == `MVC_TRIG_SEL_ADC);
  wire in_idle = (in_state_r == motor_chain_pkg::IN_IDLE);
  wire in_req  = in_auto ? adc_done : sw_start_input;
  wire in_go   = in_req && in_idle;
  // phase w sample is never read; w is rebuilt from u and v
  wire signed [17:0] iw = -(18'(iu_r) + 18'(iv_r));
  wire motor_chain_pkg::q15_t beta_nxt =
    mul_q15(18'(iv_r) - iw, `MVC_INV_SQRT3);
  wire motor_chain_pkg::q15_t id_nxt = sat16(
    36'(mul_q15(18'(alpha_r), 18'(cos_th))) +
    36'(mul_q15(18'(beta_r), 18'(sin_th))));
  wire motor_chain_pkg::q15_t iq_nxt = sat16(
    36'(mul_q15(18'(beta_r), 18'(cos_th))) -
    36'(mul_q15(18'(alpha_r), 18'(sin_th))));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_state_r         <= motor_chain_pkg::IN_IDLE;
      iu_r               <= '0;
      iv_r               <= '0;
      alpha_r            <= '0;
      beta_r             <= '0;
      d_current_feedback <= '0;
      q_current_feedback <= '0;
      input_done         <= 1'b0;
    end else begin
      input_done <= 1'b0;
      case (in_state_r)
        motor_chain_pkg::IN_IDLE: begin
          if (in_go) begin
            iu_r       <= adc_input_phase_u;
            iv_r       <= adc_input_phase_v;
            in_state_r <= motor_chain_pkg::IN_CLARKE;
          end
        end
        motor_chain_pkg::IN_CLARKE: begin
          alpha_r    <= iu_r;
          beta_r     <= beta_nxt;
          in_state_r <= motor_chain_pkg::IN_PARK;
        end
        motor_chain_pkg::IN_PARK: begin
          d_current_feedback <= id_nxt;
          q_current_feedback <= iq_nxt;
          input_done         <= 1'b1;
          in_state_r         <= motor_chain_pkg::IN_IDLE;
        end
        default: in_state_r <= motor_chain_pkg::IN_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // pi stage
  // --------------------------------------------------------------
  logic                  pi_busy_r;
  motor_chain_pkg::q15_t integ_d_r;
  motor_chain_pkg::q15_t integ_q_r;

  wire pi_req = pi_stage_chain_enable ? input_done : sw_start_pi;
  wire pi_go  = pi_req && !pi_busy_r;
  wire signed [16:0] err_d = 17'(d_current_command) -
                             17'(d_current_feedback);
  wire signed [16:0] err_q = 17'(q_current_command) -
                             17'(q_current_feedback);
  wire signed [35:0] ki_d = (36'(ki_gain) * 36'(err_d)) >>>
                            `MVC_GAIN_SHIFT;
  wire signed [35:0] ki_q = (36'(ki_gain) * 36'(err_q)) >>>
                            `MVC_GAIN_SHIFT;
  wire signed [35:0] kp_d = (36'(kp_gain) * 36'(err_d)) >>>
                            `MVC_GAIN_SHIFT;
  wire signed [35:0] kp_q = (36'(kp_gain) * 36'(err_q)) >>>
                            `MVC_GAIN_SHIFT;
  // integrator saturates in volts so it cannot wind past the output
  wire motor_chain_pkg::q15_t integ_d_nxt = sat16(36'(integ_d_r) + ki_d);
  wire motor_chain_pkg::q15_t integ_q_nxt = sat16(36'(integ_q_r) + ki_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pi_busy_r        <= 1'b0;
      pi_done          <= 1'b0;
      integ_d_r        <= '0;
      integ_q_r        <= '0;
      d_voltage_result <= '0;
      q_voltage_result <= '0;
    end else begin
      pi_busy_r <= pi_go;
      pi_done   <= pi_busy_r;
      if (pi_busy_r) begin
        integ_d_r        <= integ_d_nxt;
        integ_q_r        <= integ_q_nxt;
        d_voltage_result <= sat16(36'(integ_d_nxt) + kp_d);
        q_voltage_result <= sat16(36'(integ_q_nxt) + kp_q);
      end
    end
  end

  // --------------------------------------------------------------
  // pwm stage
  // --------------------------------------------------------------
  motor_chain_pkg::pwm_state_t pwm_state_r;
  motor_chain_pkg::q15_t       va_r;
  motor_chain_pkg::q15_t       vb_r;
  logic [15:0]                 cu_r;
  logic [15:0]                 cv_r;
  logic [15:0]                 cw_r;

  stream_if #(.W(`MVC_CMP_WIDTH)) cmp_in ();
  stream_if #(.W(`MVC_CMP_WIDTH)) cmp_out ();

  wire pwm_idle = (pwm_state_r == motor_chain_pkg::PWM_IDLE);
  wire pwm_req  = pwm_stage_chain_enable ? pi_done : sw_start_pwm;
  wire pwm_go   = pwm_req && pwm_idle;
  wire motor_chain_pkg::q15_t va_nxt = sat16(
    36'(mul_q15(18'(d_voltage_result), 18'(cos_th))) -
    36'(mul_q15(18'(q_voltage_result), 18'(sin_th))));
  wire motor_chain_pkg::q15_t vb_nxt = sat16(
    36'(mul_q15(18'(d_voltage_result), 18'(sin_th))) +
    36'(mul_q15(18'(q_voltage_result), 18'(cos_th))));
  wire motor_chain_pkg::q15_t vb_s3 =
    mul_q15(18'(vb_r), `MVC_SQRT3_HALF);
  wire motor_chain_pkg::q15_t vv = sat16(36'(vb_s3) - (36'(va_r) >>> 1));
  wire motor_chain_pkg::q15_t vw = sat16(-36'(vb_s3) - (36'(va_r) >>> 1));
  wire [15:0] half = {1'b0, pwm_period[15:1]};

  // duty about mid-carrier: compare = half + v * half
  function automatic logic [15:0] to_cmp(input motor_chain_pkg::q15_t v,
                                         input logic [15:0] h);
    logic signed [33:0] p;
    p = 34'(v) * 34'($signed({1'b0, h}));
    to_cmp = 16'(34'($signed({1'b0, h})) + (p >>> `MVC_Q15_SHIFT));
  endfunction : to_cmp

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_state_r <= motor_chain_pkg::PWM_IDLE;
      va_r        <= '0;
      vb_r        <= '0;
      cu_r        <= `MVC_ZERO16;
      cv_r        <= `MVC_ZERO16;
      cw_r        <= `MVC_ZERO16;
      pwm_done    <= 1'b0;
    end else begin
      pwm_done <= 1'b0;
      case (pwm_state_r)
        motor_chain_pkg::PWM_IDLE: begin
          if (pwm_go) pwm_state_r <= motor_chain_pkg::PWM_PARK;
        end
        motor_chain_pkg::PWM_PARK: begin
          va_r        <= va_nxt;
          vb_r        <= vb_nxt;
          pwm_state_r <= motor_chain_pkg::PWM_PHASE;
        end
        motor_chain_pkg::PWM_PHASE: begin
          cu_r        <= to_cmp(va_r, half);
          cv_r        <= to_cmp(vv, half);
          cw_r        <= to_cmp(vw, half);
          pwm_state_r <= motor_chain_pkg::PWM_PUSH;
        end
        motor_chain_pkg::PWM_PUSH: begin
          // full buffer holds the stage here: back-pressure
          if (cmp_in.ready) begin
            pwm_done    <= 1'b1;
            pwm_state_r <= motor_chain_pkg::PWM_IDLE;
          end
        end
        default: pwm_state_r <= motor_chain_pkg::PWM_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // compare buffer toward the timer
  // --------------------------------------------------------------
  assign cmp_in.valid  = (pwm_state_r == motor_chain_pkg::PWM_PUSH);
  assign cmp_in.data   = {cu_r, cv_r, cw_r};
  assign cmp_out.ready = cmp_ready;
  assign cmp_valid     = cmp_out.valid;
  assign cmp_u         = cmp_out.data[47:32];
  assign cmp_v         = cmp_out.data[31:16];
  assign cmp_w         = cmp_out.data[15:0];

  sample_fifo #(.W(`MVC_CMP_WIDTH), .DEPTH(`MVC_FIFO_DEPTH)) cmp_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr      (cmp_in.snk),
    .rd      (cmp_out.src)
  );

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence in_run_s;
    in_state_r == motor_chain_pkg::IN_CLARKE ##1
    in_state_r == motor_chain_pkg::IN_PARK ##1 input_done;
  endsequence
  sequence pwm_run_s;
    pwm_state_r == motor_chain_pkg::PWM_PARK ##1
    pwm_state_r == motor_chain_pkg::PWM_PHASE ##1
    pwm_state_r == motor_chain_pkg::PWM_PUSH;
  endsequence

  ang_start_a: assert property (ang_go |=> angle_done)
    else $error("angle stage missed an angle change");
  ang_sum_a: assert property (angle_done |->
    held_electric_angle == 16'($past(res_hi) + $past(angle_offset)))
    else $error("electric angle is not angle plus offset");
  in_auto_a: assert property (in_auto && adc_done && in_idle
    |=> in_run_s) else $error("input stage did not run on ADC done");
  ang_copy_a: assert property (adc_trig |=>
    sampled_electric_angle == $past(held_electric_angle))
    else $error("angle not captured at ADC trigger");
  pi_chain_a: assert property (pi_stage_chain_enable && input_done
    && !pi_busy_r |=> pi_busy_r ##1 pi_done)
    else $error("PI stage did not follow input stage");
  pwm_chain_a: assert property (pwm_stage_chain_enable && pi_done
    && pwm_idle |=> pwm_run_s)
    else $error("PWM stage did not follow PI stage");
  cmp_hold_a: assert property (cmp_in.valid && !cmp_in.ready
    |=> cmp_in.valid && $stable(cmp_in.data))
    else $error("compare word dropped while buffer full");
  done_pulse_a: assert property (input_done |=> !input_done)
    else $error("input done is not a single pulse");
  pi_busy_a: assert property (pi_busy_r |=> !pi_busy_r)
    else $error("PI stage restarted while busy");

endmodule : motor_vector_chain

`default_nettype wire

// file: verif/far_side_model.sv
`default_nettype none

// ------------------------------------------------------------
// resolver, a/d converter and pwm timer stand-in
// ------------------------------------------------------------
module far_side_model #(
  parameter int CONV_CYCLES = 5,
  parameter int DEAD_CYCLES = 3
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [15:0]        angle_hi,
  input  wire logic               fire,
  input  wire logic signed [15:0] cur_u,
  input  wire logic signed [15:0] cur_v,
  input  wire logic signed [15:0] cur_w,
  input  wire logic               stall,
  input  wire logic               cmp_valid,
  input  wire logic [15:0]        cmp_u,
  input  wire logic [15:0]        cmp_v,
  input  wire logic [15:0]        cmp_w,
  output logic [31:0]             resolver_angle_word,
  output logic                    adc_trig,
  output logic                    adc_done,
  output logic signed [15:0]      adc_input_phase_v,
  output logic signed [15:0]      adc_input_phase_w,
  output logic signed [15:0]      adc_input_phase_u,
  output logic                    cmp_ready,
  output int                      pops,
  output logic [47:0]             last_word,
  output int                      dead_count
);
  timeunit 1ns;
  timeprecision 1ps;

  int          conv_r;
  int          dead_r;
  logic [15:0] carrier_r;
  logic        u_on_r;
  wire         u_on_nxt = (carrier_r < last_word[47:32]);

  // low angle bits wander so only the upper word may start the angle stage
  always_ff @(posedge clk) begin
    resolver_angle_word <= {angle_hi,
                            resolver_angle_word[15:0] + 16'h0001};
    adc_trig  <= fire;
    adc_done  <= (conv_r == 1);
    cmp_ready <= ~stall;
    carrier_r <= carrier_r + 16'h0001;
    u_on_r    <= u_on_nxt;
    // a change of u_on_nxt restarts the dead count; cycles with it running add to dead_count
    if (u_on_nxt != u_on_r) dead_r <= DEAD_CYCLES;
    else if (dead_r > 0) dead_r <= dead_r - 1;
    if (dead_r > 0) dead_count <= dead_count + 1;
    conv_r    <= fire ? CONV_CYCLES : (conv_r > 0 ? conv_r - 1 : 0);
    if (conv_r == 1) begin
      adc_input_phase_v <= cur_v;
      adc_input_phase_w <= cur_w;
      adc_input_phase_u <= cur_u;
    end else begin
      // stale results must not look valid between conversions
      adc_input_phase_v <= ~adc_input_phase_v;
      adc_input_phase_w <= ~adc_input_phase_w;
      adc_input_phase_u <= ~adc_input_phase_u;
    end
    if (cmp_valid && cmp_ready) begin
      pops      <= pops + 1;
      last_word <= {cmp_u, cmp_v, cmp_w};
    end
    if (sys_rst) begin
      resolver_angle_word <= 32'h00000000;
      adc_trig            <= 1'b0;
      adc_done            <= 1'b0;
      conv_r              <= 0;
      adc_input_phase_v   <= 16'h0000;
      adc_input_phase_w   <= 16'h0000;
      adc_input_phase_u   <= 16'h0000;
      cmp_ready           <= 1'b0;
      pops                <= 0;
      last_word           <= 48'h000000000000;
      carrier_r           <= 16'h0000;
      u_on_r              <= 1'b0;
      dead_r              <= 0;
      dead_count          <= 0;
    end
  end

endmodule : far_side_model

`default_nettype wire

// file: verif/test_motor_vector_control_chain.sv
`default_nettype none
`define CHK(g, e) check_val(48'(g), 48'(e), `__LINE__)

module test_motor_vector_control_chain;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [15:0] hi, off, u, v, w, held, d, q;
  } row_t;

  // ------------------------------------------------------------
  // stimulus and wiring
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] angle_hi = 16'h0000;
  logic [15:0] angle_offset = 16'h0000;
  logic [15:0] cur_u = 16'h0000;
  logic [15:0] cur_v = 16'h0000;
  logic [15:0] cur_w = 16'h0000;
  logic        stall = 1'b0;
  logic [3:0]  kick_r = 4'h0;
  logic [1:0]  sel = 2'h2;
  logic        pi_chain = 1'b1;
  logic        pwm_chain = 1'b1;
  logic [15:0] d_cmd = 16'h0000;
  logic [15:0] q_cmd = 16'h0000;
  logic [15:0] kp = 16'h0000;
  logic [31:0] res_word;
  logic        adc_trig;
  logic        adc_done;
  logic [15:0] ph_v, ph_w, ph_u;
  logic        cmp_ready, cmp_valid;
  logic [15:0] cmp_u, cmp_v, cmp_w;
  logic [15:0] held, sampled;
  logic [15:0] d_fb, q_fb, vd, vq;
  wire  [3:0]  dones;
  int          pops;
  logic [47:0] last_word;
  int          dead_count;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          p0;
  int          cnt[4] = '{default: 0};
  int          snap[4];
  row_t        rows[3] = '{
    '{16'hF000, 16'h0000, 16'h0000, 16'h0000, 16'h1234,
      16'hF000, 16'h0000, 16'h0000},
    '{16'h0800, 16'hF800, 16'h2000, 16'h0000, 16'h7FFF,
      16'h0000, 16'h2000, 16'h1279},
    '{16'h3000, 16'h1000, 16'h2000, 16'h0000, 16'h8000,
      16'h4000, 16'h1279, 16'hE000}};
  logic [1:0]  codes[3] = '{2'h0, 2'h1, 2'h3};

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    for (int i = 0; i < 4; i++) if (dones[i] === 1'b1) cnt[i]++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  motor_vector_chain u_motor_vector_chain (
    .clk(clk), .sys_rst(sys_rst), .resolver_angle_word(res_word),
    .angle_offset(angle_offset), .adc_trig(adc_trig),
    .adc_done(adc_done), .adc_input_phase_v(ph_v),
    .adc_input_phase_w(ph_w), .adc_input_phase_u(ph_u),
    .input_stage_trigger_sel(sel), .pi_stage_chain_enable(pi_chain),
    .pwm_stage_chain_enable(pwm_chain), .sw_start_input(kick_r[1]),
    .sw_start_pi(kick_r[2]), .sw_start_pwm(kick_r[3]),
    .d_current_command(d_cmd), .q_current_command(q_cmd),
    .kp_gain(kp), .ki_gain(16'h0000), .pwm_period(16'h0100),
    .held_electric_angle(held), .sampled_electric_angle(sampled),
    .d_current_feedback(d_fb), .q_current_feedback(q_fb),
    .d_voltage_result(vd), .q_voltage_result(vq),
    .angle_done(dones[0]), .input_done(dones[1]), .pi_done(dones[2]),
    .pwm_done(dones[3]), .cmp_valid(cmp_valid), .cmp_ready(cmp_ready),
    .cmp_u(cmp_u), .cmp_v(cmp_v), .cmp_w(cmp_w));

  far_side_model u_far_side_model (
    .clk(clk), .sys_rst(sys_rst), .angle_hi(angle_hi),
    .fire(kick_r[0]), .cur_u(cur_u), .cur_v(cur_v), .cur_w(cur_w),
    .stall(stall), .cmp_valid(cmp_valid), .cmp_u(cmp_u),
    .cmp_v(cmp_v), .cmp_w(cmp_w), .resolver_angle_word(res_word),
    .adc_trig(adc_trig), .adc_done(adc_done),
    .adc_input_phase_v(ph_v), .adc_input_phase_w(ph_w),
    .adc_input_phase_u(ph_u), .cmp_ready(cmp_ready), .pops(pops),
    .last_word(last_word), .dead_count(dead_count));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check_val(input logic [47:0] g, input logic [47:0] e,
                           input int line);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR at %0t: line %0d got %h want %h", $time, line, g, e);
    end
  endtask : check_val

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // hold a start for n edges; n above one lands on a busy stage
  task automatic kick(input logic [3:0] k, input int n);
    @(posedge clk);
    kick_r <= k;
    repeat (n) @(posedge clk);
    kick_r <= 4'h0;
  endtask : kick

  task automatic wait_done(input int idx);
    for (int t = 0; t < 60; t++) begin
      @(posedge clk);
      #1;
      if (dones[idx] === 1'b1) return;
    end
    mismatches++;
    $display("ERROR at %0t: no completion on stage %0d", $time, idx);
  endtask : wait_done

  task automatic mark;
    // let the edge's pulse count settle before taking the snapshot
    #1;
    snap = cnt;
  endtask : mark

  function automatic logic near(input logic signed [15:0] a,
                                input logic signed [15:0] b);
    int d;
    d = int'(a) - int'(b);
    // the sine is approximated, so the transform is judged to a band
    return (^a !== 1'bx) && d <= 64 && d >= -64;
  endfunction : near

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(held, 16'h0000);
    `CHK(cmp_valid, 1'b0);
    `CHK(dones, 4'h0);
    $display("test reset finished");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      angle_hi     <= rows[i].hi;
      angle_offset <= rows[i].off;
      cur_u        <= rows[i].u;
      cur_v        <= rows[i].v;
      cur_w        <= rows[i].w;
      wait_done(0);
      `CHK(held, rows[i].held);
      kick(4'h1, 1);
      wait_done(1);
      `CHK(sampled, rows[i].held);
      `CHK(near(d_fb, rows[i].d), 1'b1);
      `CHK(near(q_fb, rows[i].q), 1'b1);
      wait_done(2);
      `CHK(vd, 16'h0000);
      `CHK(vq, 16'h0000);
      wait_done(3);
      repeat (3) @(posedge clk);
      #1;
      `CHK(pops, i + 1);
      `CHK(last_word, {3{16'h0080}});
    end
    $display("test rows finished");
    mark();
    repeat (20) @(posedge clk);
    #1;
    `CHK(cnt[0] - snap[0], 0);
    kick(4'h1, 1);
    angle_hi <= 16'h5000;
    wait_done(0);
    `CHK(held, 16'h6000);
    wait_done(3);
    `CHK(sampled, 16'h4000);
    $display("test capture finished");
    @(posedge clk);
    cur_u <= 16'h0000;
    kp    <= 16'h0100;
    d_cmd <= 16'h0100;
    q_cmd <= 16'hFE00;
    kick(4'h1, 1);
    wait_done(1);
    `CHK(d_fb, 16'h0000);
    wait_done(2);
    `CHK(vd, 16'h0100);
    `CHK(vq, 16'hFE00);
    wait_done(3);
    $display("test pi finished");
    @(posedge clk);
    pi_chain  <= 1'b0;
    pwm_chain <= 1'b0;
    kp        <= 16'h0000;
    mark();
    kick(4'h4, 2);
    repeat (8) @(posedge clk);
    #1;
    `CHK(cnt[2] - snap[2], 1);
    `CHK(vd, 16'h0000);
    `CHK(cnt[3] - snap[3], 0);
    mark();
    foreach (codes[k]) begin
      @(posedge clk);
      sel <= codes[k];
      kick(4'h1, 1);
      repeat (12) @(posedge clk);
    end
    #1;
    `CHK(cnt[1] - snap[1], 0);
    kick(4'h2, 3);
    repeat (8) @(posedge clk);
    #1;
    `CHK(cnt[1] - snap[1], 1);
    `CHK(cnt[2] - snap[2], 0);
    $display("test software starts finished");
    mark();
    p0 = pops;
    @(posedge clk);
    stall <= 1'b1;
    repeat (9) begin
      kick(4'h8, 1);
      repeat (6) @(posedge clk);
    end
    #1;
    `CHK(cnt[3] - snap[3], 8);
    `CHK(pops - p0, 0);
    `CHK(cmp_valid, 1'b1);
    @(posedge clk);
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    `CHK(pops - p0, 9);
    `CHK(last_word, {3{16'h0080}});
    `CHK(cnt[3] - snap[3], 9);
    `CHK(cmp_valid, 1'b0);
    `CHK(dead_count > 0, 1'b1);
    $display("test buffer finished");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(held, 16'h0000);
    `CHK(vd, 16'h0000);
    `CHK(dones, 4'h0);
    @(posedge clk);
    #1;
    `CHK(held, 16'h6000);
    `CHK(dones, 4'h1);
    $display("test mid reset finished");
    results();
  end

endmodule : test_motor_vector_control_chain

`default_nettype wire
